/* File: imds_regs.svh */
// offsets, field positions and reset values of the descriptor status block
// assumes inclusion from the package and the block's single design file
`ifndef IMDS_REGS_SVH
`define IMDS_REGS_SVH

// avalon byte offsets (word n of the descriptor at 4*n)
`define IMDS_OFF_DW0        6'h00
`define IMDS_OFF_DW7        6'h1C
`define IMDS_OFF_IRQ_STAT   6'h20
`define IMDS_OFF_IRQ_MASK   6'h24

// descriptor field positions
`define IMDS_DW_SCHED       3'd2
`define IMDS_DW_FLAGS       3'd3
`define IMDS_DW_RESULT      3'd4
`define IMDS_DW_COUNT_LO    3'd5
`define IMDS_FRAME_LSB      3
`define IMDS_FRAME_MSB      7
`define IMDS_VALID_BIT      31
`define IMDS_HALT_BIT       30
`define IMDS_XFER_MSB       14
`define IMDS_RESULT_LSB     8
`define IMDS_ERR_BIT        0
`define IMDS_BABBLE_BIT     1
`define IMDS_UNDERRUN_BIT   2

// interrupt status bits
`define IMDS_IRQ_DONE       0
`define IMDS_IRQ_ERROR      1
`define IMDS_IRQ_HALT       2

// reset values
`define IMDS_DW_RESET       32'h0000_0000
`define IMDS_IRQ_RESET      3'h0

`endif

/* File: imds_pkg.sv */
// types shared by the descriptor status block
// assumes the offsets header sits in the same folder
package imds_pkg;
    `include "imds_regs.svh"

    typedef enum logic [0:0] {
        IMDS_IDLE,
        IMDS_BUSY
    } imds_state_e;

    typedef struct packed {
        logic        tick;
        logic [2:0]  index;
        logic [4:0]  frame;
    } imds_uframe_s;

    typedef struct packed {
        logic        done;
        logic        dir_in;
        logic [11:0] count;
        logic        xact_err;
        logic        babble;
        logic        underrun;
        logic        stall;
    } imds_result_s;

    typedef struct packed {
        logic        req;
        logic [2:0]  index;
    } imds_send_s;
endpackage

/* File: imds_desc_status.sv */
// isochronous microframe descriptor: scheduling, result write-back, avalon slave
// assumes one clock, usb engine pulses synchronous to core_clk
// What this block does
// - an in count is written for a microframe only when its armed bit is set and the frame matches.
// - the microframe 2 count is split, top four bits in dw6[3:0] and low eight in dw5[31:24].
// - counts of microframes 3, 1 and 0 sit at dw6[15:4], dw5[23:12] and dw5[11:0].
// - eight 3-bit result fields are packed from microframe 7 at dw4[31:29] to 0 at dw4[10:8].
// - a result field is updated only once the bus has finished that microframe's payload.
// - result bit 0 flags a transaction error in either direction.
// - result bit 1 flags babble, for in transactions only.
// - result bit 2 flags underrun, for out transactions only.
// - armed bits are consulted only when the scheduled frame equals the bus frame.
// - software can only set armed bits; hardware checks for one and clears after processing.
// - all armed bits set sends every microframe; pattern 0x55 sends microframes 0, 2, 4, 6.
// - a stall sets the halt flag and clears the valid flag.
// - the target frame comes from scheduling bits 7:3, bits 2:0 ignored.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "imds_regs.svh"
module imds_desc_status
    import imds_pkg::*;
#(
    parameter int UFRAMES = 8,
    parameter int COUNT_W = 12
)
(
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic [5:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire imds_pkg::imds_uframe_s uframe_in,
    input  wire imds_pkg::imds_result_s result_in,
    output imds_pkg::imds_send_s        send_out,
    output logic                        irq
);
    import imds_pkg::*;

    // dw4..dw7 packing is fixed: eight microframes of 12-bit counts
    if (UFRAMES != 8 || COUNT_W != 12) begin : g_bad_geometry
        $error("unsupported microframe count or count width");
    end

    logic [31:0]  dw_q [8];
    logic [31:0]  dw_d [8];
    imds_state_e  state_q, state_d;
    logic [2:0]   cur_q, cur_d;
    imds_send_s   send_q, send_d;
    logic [2:0]   stat_q, stat_d;
    logic [2:0]   mask_q, mask_d;
    logic         irq_q, irq_d;
    logic         wait_q, wait_d;
    logic [31:0]  rdata_q, rdata_d;

    logic         access;
    logic         commit;
    logic         sel_dw;
    logic         match;
    logic         valid;
    logic [31:0]  wmask;
    logic [95:0]  counts;
    logic [2:0]   res_bits;
    logic [2:0]   events;

    assign access = avs_read | avs_write;
    // write lands at the edge where waitrequest is seen low
    assign commit = avs_write & ~wait_q;
    assign sel_dw = avs_address <= `IMDS_OFF_DW7;
    assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign match  = dw_q[`IMDS_DW_SCHED][`IMDS_FRAME_MSB:`IMDS_FRAME_LSB]
                    == uframe_in.frame;
    assign valid  = dw_q[`IMDS_DW_FLAGS][`IMDS_VALID_BIT];

    always_comb begin
        res_bits = 3'h0;
        res_bits[`IMDS_ERR_BIT]      = result_in.xact_err;
        res_bits[`IMDS_BABBLE_BIT]   = result_in.babble & result_in.dir_in;
        res_bits[`IMDS_UNDERRUN_BIT] = result_in.underrun & ~result_in.dir_in;
    end

    // descriptor words, scheduler
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            dw_d[i] = dw_q[i];
        end
        state_d = state_q;
        cur_d   = cur_q;
        send_d  = '{req: 1'b0, index: cur_q};
        events  = 3'h0;
        counts  = {dw_q[7], dw_q[6], dw_q[5]};

        if (commit && sel_dw) begin
            dw_d[avs_address[4:2]] = (dw_q[avs_address[4:2]] & ~wmask)
                                   | (avs_writedata & wmask);
            if (avs_address[4:2] == `IMDS_DW_RESULT) begin
                // armed bits only go 0 to 1 from software
                dw_d[`IMDS_DW_RESULT][7:0] = dw_q[`IMDS_DW_RESULT][7:0]
                    | (avs_writedata[7:0] & wmask[7:0]);
            end
            counts = {dw_d[7], dw_d[6], dw_d[5]};
        end

        case (state_q)
            IMDS_IDLE: begin
                // only a pending armed bit of the matching frame starts a send
                if (uframe_in.tick && valid && match &&
                    dw_q[`IMDS_DW_RESULT][uframe_in.index]) begin
                    send_d  = '{req: 1'b1, index: uframe_in.index};
                    cur_d   = uframe_in.index;
                    state_d = IMDS_BUSY;
                end
            end
            IMDS_BUSY: begin
                // all write-back in one cycle so a read sees old or new, never a mix
                if (result_in.done) begin
                    dw_d[`IMDS_DW_RESULT][`IMDS_RESULT_LSB + 3*cur_q +: 3] = res_bits;
                    dw_d[`IMDS_DW_RESULT][cur_q] = 1'b0;
                    if (result_in.dir_in) begin
                        counts[12*cur_q +: 12] = result_in.count;
                        dw_d[`IMDS_DW_FLAGS][`IMDS_XFER_MSB:0] = {3'h0, result_in.count};
                    end
                    if (result_in.stall) begin
                        dw_d[`IMDS_DW_FLAGS][`IMDS_HALT_BIT]  = 1'b1;
                        dw_d[`IMDS_DW_FLAGS][`IMDS_VALID_BIT] = 1'b0;
                    end
                    events[`IMDS_IRQ_DONE]  = 1'b1;
                    events[`IMDS_IRQ_ERROR] = |res_bits;
                    events[`IMDS_IRQ_HALT]  = result_in.stall;
                    state_d = IMDS_IDLE;
                end
            end
            default: state_d = IMDS_IDLE;
        endcase
        dw_d[5] = counts[31:0];
        dw_d[6] = counts[63:32];
        dw_d[7] = counts[95:64];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 8; i++) begin
                dw_q[i] <= `IMDS_DW_RESET;
            end
            state_q <= IMDS_IDLE;
            cur_q   <= 3'h0;
            send_q  <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                dw_q[i] <= dw_d[i];
            end
            state_q <= state_d;
            cur_q   <= cur_d;
            send_q  <= send_d;
        end
    end

    // interrupt status, mask, bus answer
    always_comb begin
        stat_d  = stat_q;
        mask_d  = mask_q;
        rdata_d = rdata_q;
        if (commit && avs_address == `IMDS_OFF_IRQ_STAT && avs_byteenable[0]) begin
            stat_d = stat_q & ~avs_writedata[2:0];
        end
        if (commit && avs_address == `IMDS_OFF_IRQ_MASK && avs_byteenable[0]) begin
            mask_d = avs_writedata[2:0];
        end
        // a new event beats a clear in the same cycle
        stat_d = stat_d | events;
        irq_d  = |(stat_d & mask_d);
        // one wait cycle, then the answer
        wait_d = ~(access & wait_q);
        if (access && wait_q) begin
            if (sel_dw) begin
                rdata_d = dw_q[avs_address[4:2]];
            end else if (avs_address == `IMDS_OFF_IRQ_STAT) begin
                rdata_d = {29'h0, stat_q};
            end else if (avs_address == `IMDS_OFF_IRQ_MASK) begin
                rdata_d = {29'h0, mask_q};
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q  <= `IMDS_IRQ_RESET;
            mask_q  <= `IMDS_IRQ_RESET;
            irq_q   <= 1'b0;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            irq_q   <= irq_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign send_out        = send_q;
    assign irq             = irq_q;

    // checks
    logic [7:0] armed;
    logic       in_done;
    assign armed   = dw_q[`IMDS_DW_RESULT][7:0];
    assign in_done = state_q == IMDS_BUSY && result_in.done && result_in.dir_in;

    a_send_needs_arm: assert property (@(posedge core_clk) disable iff (!arst_n)
        send_q.req |-> $past(armed[uframe_in.index]))
        else $error("send without armed bit");
    a_send_needs_frame: assert property (@(posedge core_clk) disable iff (!arst_n)
        (uframe_in.tick && !match) |=> !send_q.req)
        else $error("send in wrong frame");
    a_send_needs_valid: assert property (@(posedge core_clk) disable iff (!arst_n)
        (uframe_in.tick && !valid) |=> !send_q.req)
        else $error("send while descriptor invalid");
    a_arm_cleared: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done) |=> !armed[$past(cur_q)])
        else $error("armed bit not cleared");
    a_arm_sw_no_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_IDLE) |=> ((armed & $past(armed)) == $past(armed)))
        else $error("armed bit lost without processing");
    a_babble_in_only: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && !result_in.dir_in)
        |=> !dw_q[`IMDS_DW_RESULT][`IMDS_RESULT_LSB + 3*$past(cur_q) + 1])
        else $error("babble on out");
    a_underrun_out: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && result_in.dir_in)
        |=> !dw_q[`IMDS_DW_RESULT][`IMDS_RESULT_LSB + 3*$past(cur_q) + 2])
        else $error("underrun on in");
    a_err_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done)
        |=> dw_q[`IMDS_DW_RESULT][`IMDS_RESULT_LSB + 3*$past(cur_q)] == $past(result_in.xact_err))
        else $error("error bit wrong");
    a_count_slot: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && result_in.dir_in)
        |=> ({dw_q[7], dw_q[6], dw_q[5]} >> (12*$past(cur_q))) % 4096
            == $past(result_in.count))
        else $error("count in wrong slot");
    a_halt_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && result_in.stall)
        |=> dw_q[`IMDS_DW_FLAGS][`IMDS_HALT_BIT] && !valid)
        else $error("halt without valid clear");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        irq == |(stat_q & mask_q))
        else $error("irq not status and mask");
    a_wait_one: assert property (@(posedge core_clk) disable iff (!arst_n)
        (access && wait_q) |=> !wait_q ##1 wait_q)
        else $error("bus answer timing");

    // outside done and software writes, the result and count words stand still
    a_result_waits_done: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(state_q == IMDS_BUSY && result_in.done)
        && !(commit && sel_dw && avs_address[4:2] == `IMDS_DW_RESULT)
        |=> $stable(dw_q[`IMDS_DW_RESULT][31:`IMDS_RESULT_LSB]))
        else $error("result field changed before done");
    a_counts_wait_done: assert property (@(posedge core_clk) disable iff (!arst_n)
        !in_done && !(commit && sel_dw && avs_address[4:2] >= `IMDS_DW_COUNT_LO)
        |=> $stable({dw_q[7], dw_q[6], dw_q[5]}))
        else $error("count changed without in done");
    a_in_copies_xfer: assert property (@(posedge core_clk) disable iff (!arst_n)
        in_done |=> dw_q[`IMDS_DW_FLAGS][`IMDS_XFER_MSB:0] == {3'h0, $past(result_in.count)})
        else $error("in count not copied");

    // slots spelled out bit by bit, not through the shift of the write-back
    a_uf0_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h0) |=> dw_q[5][11:0] == $past(result_in.count))
        else $error("count slot 0");
    a_uf1_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h1) |=> dw_q[5][23:12] == $past(result_in.count))
        else $error("count slot 1");
    a_uf2_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h2) |=> {dw_q[6][3:0], dw_q[5][31:24]} == $past(result_in.count))
        else $error("count slot 2");
    a_uf3_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h3) |=> dw_q[6][15:4] == $past(result_in.count))
        else $error("count slot 3");
    a_uf4_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h4) |=> dw_q[6][27:16] == $past(result_in.count))
        else $error("count slot 4");
    a_uf5_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h5) |=> {dw_q[7][7:0], dw_q[6][31:28]} == $past(result_in.count))
        else $error("count slot 5");
    a_uf6_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h6) |=> dw_q[7][19:8] == $past(result_in.count))
        else $error("count slot 6");
    a_uf7_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_done && cur_q == 3'h7) |=> dw_q[7][31:20] == $past(result_in.count))
        else $error("count slot 7");

    // result fields rebuilt from the raw engine flags
    a_uf0_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && cur_q == 3'h0)
        |=> dw_q[`IMDS_DW_RESULT][10:8]
            == {$past(result_in.underrun && !result_in.dir_in),
                $past(result_in.babble && result_in.dir_in), $past(result_in.xact_err)})
        else $error("result field 0");
    a_uf3_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && cur_q == 3'h3)
        |=> dw_q[`IMDS_DW_RESULT][19:17]
            == {$past(result_in.underrun && !result_in.dir_in),
                $past(result_in.babble && result_in.dir_in), $past(result_in.xact_err)})
        else $error("result field 3");
    a_uf7_result: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == IMDS_BUSY && result_in.done && cur_q == 3'h7)
        |=> dw_q[`IMDS_DW_RESULT][31:29]
            == {$past(result_in.underrun && !result_in.dir_in),
                $past(result_in.babble && result_in.dir_in), $past(result_in.xact_err)})
        else $error("result field 7");

    // send side and flags
    a_valid_sw_only: assert property (@(posedge core_clk) disable iff (!arst_n)
        !valid && !(commit && sel_dw && avs_address[4:2] == `IMDS_DW_FLAGS) |=> !valid)
        else $error("valid set by hardware");
    a_send_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
        send_q.req |=> !send_q.req)
        else $error("send longer than one cycle");
    a_send_index: assert property (@(posedge core_clk) disable iff (!arst_n)
        send_q.req |-> send_q.index == $past(uframe_in.index))
        else $error("send for wrong microframe");
    a_send_on_match: assert property (@(posedge core_clk) disable iff (!arst_n)
        (uframe_in.tick && state_q == IMDS_IDLE && valid && armed[uframe_in.index]
         && dw_q[`IMDS_DW_SCHED][`IMDS_FRAME_MSB:`IMDS_FRAME_LSB] == uframe_in.frame)
        |=> send_q.req)
        else $error("armed matching microframe not sent");
    a_irq_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(commit && avs_address == `IMDS_OFF_IRQ_STAT)
        |=> (stat_q & $past(stat_q)) == $past(stat_q))
        else $error("status bit lost without a clear");

    c_send_in: cover property (@(posedge core_clk) disable iff (!arst_n)
        send_q.req ##[1:50] (result_in.done && result_in.dir_in));
    c_stall: cover property (@(posedge core_clk) disable iff (!arst_n)
        result_in.done && result_in.stall && state_q == IMDS_BUSY);
    c_all_armed: cover property (@(posedge core_clk) disable iff (!arst_n)
        armed == 8'hFF && valid);
    c_irq: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(irq));
    c_alt_armed: cover property (@(posedge core_clk) disable iff (!arst_n)
        armed == 8'h55 && valid);
endmodule // imds_desc_status

/* File: imds_usb_model.sv */
// usb endpoint model: answers each send request with one done pulse
// assumes send_out is registered on core_clk; cfg and delay set by the bench
`timescale 1ns/1ps
module imds_usb_model
    import imds_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire imds_pkg::imds_send_s   send_out,
    input  wire imds_pkg::imds_result_s cfg,
    input  wire logic [3:0]             delay,
    output imds_pkg::imds_result_s      result_in,
    output logic                        busy
);
    logic [3:0]   cnt;
    logic         done;
    imds_result_s last;
    // fields mean nothing without done, so show the inverse there
    always_comb begin
        result_in = done ? last : ~last;
        result_in.done = done;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            last <= '0;
        end else begin
            done <= 1'b0;
            if (send_out.req && !busy) begin
                busy <= 1'b1;
                cnt <= delay;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                done <= 1'b1;
                last <= cfg;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule // imds_usb_model

/* File: tb_imds_desc_status.sv */
// bench for the descriptor status block with the endpoint model
// assumes only a bounded bus answer time; each wait gives up after 50 cycles
`timescale 1ns/1ps
module tb_imds_desc_status;
    import imds_pkg::*;
    logic         core_clk = 0;
    logic         arst_n = 0;
    logic [5:0]   avs_address = '0;
    logic         avs_read = 0;
    logic         avs_write = 0;
    logic [31:0]  avs_writedata = '0;
    logic [3:0]   avs_byteenable = 4'hF;
    logic [3:0]   lanes = 4'hF;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    imds_uframe_s uframe_in = '0;
    imds_result_s result_in;
    imds_result_s cfg = '0;
    imds_send_s   send_out;
    logic         irq;
    logic         busy;
    logic [3:0]   delay = 4'h0;
    logic [7:0]   got;
    logic [31:0]  rd;
    logic [95:0]  cexp;
    int           bad_count = 0;
    int           n_checks = 0;
    always #2.5 core_clk = ~core_clk;
    imds_desc_status imds_desc_status_i (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .uframe_in(uframe_in), .result_in(result_in),
        .send_out(send_out), .irq(irq));
    imds_usb_model imds_usb_model_i (.core_clk(core_clk), .arst_n(arst_n),
        .send_out(send_out), .cfg(cfg), .delay(delay), .result_in(result_in), .busy(busy));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= lanes;
        i = 0;
        // held until the edge where waitrequest is seen low
        do begin
            @(posedge core_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i >= 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, rd, exp);
    endtask
    // pk nonzero: read the result word before done lands
    task automatic tick(input logic [2:0] k, input logic [4:0] f, input logic [31:0] pk);
        int i;
        @(posedge core_clk);
        uframe_in <= '{1'b1, k, f};
        @(posedge core_clk);
        uframe_in.tick <= 1'b0;
        @(posedge core_clk);
        if (send_out.req === 1'b1)
            got[send_out.index] = 1'b1;
        if (pk != 32'h0000_0000)
            rdc("early result", 6'h10, pk);
        @(posedge core_clk);
        for (i = 0; busy !== 1'b0 && i < 50; i++)
            @(posedge core_clk);
        if (i >= 50) begin
            bad_count++;
            tally_and_finish();
        end
        repeat (3) @(posedge core_clk);
    endtask
    task automatic t_reset();
        for (int a = 0; a <= 40; a += 4)
            rdc("reset word", a[5:0], 32'h0000_0000);
        wr(6'h28, 32'hFFFF_FFFF);
        rdc("unmapped", 6'h28, 32'h0000_0000);
    endtask
    task automatic t_all();
        got = '0;
        wr(6'h08, 32'h0000_002F);
        wr(6'h0C, 32'h8000_0000);
        wr(6'h10, 32'h0000_00FF);
        cfg = '{1'b0, 1'b1, 12'h000, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 8; k++) begin
            cfg.count = 12'h3A0 + 12'(k);
            cexp[12*k +: 12] = cfg.count;
            tick(k[2:0], 5'd5, 32'h0000_0000);
        end
        check("sent all", {24'h0, got}, 32'h0000_00FF);
        rdc("dw4 in", 6'h10, 32'h4924_9200);
        rdc("dw5", 6'h14, cexp[31:0]);
        rdc("dw6", 6'h18, cexp[63:32]);
        rdc("dw7", 6'h1C, cexp[95:64]);
    endtask
    task automatic t_alt();
        got = '0;
        wr(6'h10, 32'h4924_9255);
        for (int k = 0; k < 8; k++)
            tick(k[2:0], 5'd6, 32'h0000_0000);
        check("wrong frame", {24'h0, got}, 32'h0000_0000);
        cfg = '{1'b0, 1'b0, 12'hABC, 1'b1, 1'b1, 1'b1, 1'b0};
        delay = 4'h6;
        tick(3'd0, 5'd5, 32'h4924_9255);
        for (int k = 1; k < 8; k++)
            tick(k[2:0], 5'd5, 32'h0000_0000);
        check("sent alt", {24'h0, got}, 32'h0000_0055);
        rdc("dw4 out", 6'h10, 32'h5555_5500);
        rdc("out count", 6'h14, cexp[31:0]);
        delay = 4'h0;
    endtask
    task automatic t_irq();
        rdc("irq stat", 6'h20, 32'h0000_0003);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(6'h24, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("irq on", {31'h0, irq}, 32'h0000_0001);
        wr(6'h20, 32'h0000_0001);
        rdc("irq clr", 6'h20, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        check("irq off", {31'h0, irq}, 32'h0000_0000);
        wr(6'h20, 32'h0000_0002);
    endtask
    task automatic t_stall();
        wr(6'h10, 32'h0000_0003);
        wr(6'h10, 32'h0000_0000);
        rdc("armed keep", 6'h10, 32'h0000_0003);
        lanes = 4'hE;
        wr(6'h10, 32'h0000_00FC);
        lanes = 4'hF;
        rdc("armed lane off", 6'h10, 32'h0000_0003);
        wr(6'h24, 32'h0000_0004);
        cfg = '{1'b0, 1'b1, 12'h7FF, 1'b0, 1'b0, 1'b0, 1'b1};
        tick(3'd0, 5'd5, 32'h0000_0000);
        rdc("halt", 6'h0C, 32'h4000_07FF);
        check("irq halt", {31'h0, irq}, 32'h0000_0001);
        got = '0;
        tick(3'd1, 5'd5, 32'h0000_0000);
        check("no send", {24'h0, got}, 32'h0000_0000);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_all();
        t_alt();
        t_irq();
        t_stall();
        tally_and_finish();
    end
endmodule // tb_imds_desc_status
